// ### nlc_pkg.sv
// Constants, types and helper functions of the node list command handler
package nlc_pkg;
  // Overview of operation
  // RL1 - Opcode 3E returns peripheral fault list
  // RL2 - Fault list refreshed cyclically without host request
  // RL3 - Fault bit 0: healthy, disabled or absent
  // RL4 - Fault bit 1: node reports peripheral fault
  // RL5 - Host sends list reads without payload
  // RL6 - List payload eight bytes, fixed bit order
  // RL7 - Opcode 3F writes ident code to address 0
  // RL8 - Ident code forwarded unchanged, no check
  // RL9 - Host uses ident write only for identification
  // RL10 - Ident request one byte, response header only
  // RL11 - Header-only commands return no payload
  // RL12 - Opcode 43 records permanent node parameter
  // RL13 - Permanent parameters kept in non-volatile storage
  // RL14 - Stored parameters sent to nodes at power-up
  // RL15 - Parameter request: address byte, parameter nibble
  // RL16 - Opcode 44 returns projected node list
  // RL17 - Projected bit 1 expected, 0 not
  // RL18 - Opcode 45 returns enabled node list
  // RL19 - Enabled bit 1 enabled, 0 disabled
  // RL20 - Detected list command returns eight bytes
  // RL21 - Detected bit 1 detected, 0 otherwise
  // RL22 - Response echoes opcode, handshake bit, error
  // RL23 - Request: opcode, handshake bit, segment select

  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OP_FAULT_LIST   = 8'h3E;
  localparam logic [7:0] OP_EXT_IDENT    = 8'h3F;
  localparam logic [7:0] OP_PERM_PARAM   = 8'h43;
  localparam logic [7:0] OP_PROJ_LIST    = 8'h44;
  localparam logic [7:0] OP_ENABLED_LIST = 8'h45;
  localparam logic [7:0] OP_DETECT_LIST  = 8'h46;

  // ****************************************
  // Frame layout
  // ****************************************
  localparam logic [3:0] HDR_BYTES     = 4'h2;
  localparam logic [3:0] LIST_BYTES    = 4'h8;
  localparam logic [3:0] RSP_LIST_LEN  = 4'hA;
  localparam logic [2:0] LEN_LIST_REQ  = 3'h2;
  localparam logic [2:0] LEN_IDENT_REQ = 3'h3;
  localparam logic [2:0] LEN_PARAM_REQ = 3'h4;
  localparam logic [2:0] MAX_REQ_BYTES = 3'h4;
  localparam int         T_BIT         = 7;
  localparam int         SEG_BIT       = 0;
  localparam int         AB_BIT        = 5;
  localparam int         NODES         = 64;
  localparam int         ADDR_W        = 6;
  localparam logic [3:0] PARAM_DEFAULT = 4'hF;
  localparam logic [ADDR_W-1:0] LAST_NODE = 6'h3F;

  // ****************************************
  // Error codes
  // ****************************************
  localparam logic [6:0] ERR_NONE    = 7'h00;
  localparam logic [6:0] ERR_OPCODE  = 7'h01;
  localparam logic [6:0] ERR_LENGTH  = 7'h02;
  localparam logic [6:0] ERR_SEGMENT = 7'h03;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ         = 20_000_000;
  localparam int REFRESH_US     = 100;
  localparam int REFRESH_CYCLES = (CLK_HZ / 1_000_000) * REFRESH_US;

  typedef enum logic {NODE_WR_IDENT, NODE_WR_PARAM} nlc_node_wr_type;

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [2:0] nlc_req_len(input logic [7:0] op);
    case (op)
      OP_FAULT_LIST, OP_PROJ_LIST, OP_ENABLED_LIST, OP_DETECT_LIST: return LEN_LIST_REQ; // RL5
      OP_EXT_IDENT:  return LEN_IDENT_REQ; // RL10
      OP_PERM_PARAM: return LEN_PARAM_REQ; // RL15
      default:       return 3'h0;
    endcase
  endfunction : nlc_req_len

  // Payload in send order: first byte in the top bits; bit 0 of A0 and B0 bytes is unused
  function automatic logic [63:0] nlc_pack_list(input logic [63:0] list);
    logic [63:0] packed_bytes;
    logic [7:0]  one_byte;
    packed_bytes = 64'h0000_0000_0000_0000;
    for (int k = 0; k < 8; k++) begin
      one_byte = list[k*8 +: 8];
      if (k == 0 || k == 4) begin
        one_byte[0] = 1'b0;
      end
      packed_bytes[(7-k)*8 +: 8] = one_byte; // RL6
    end
    return packed_bytes;
  endfunction : nlc_pack_list
endpackage : nlc_pkg

// ### nlc_if.sv
// Byte stream carrier between host controller and node list command handler
`timescale 1ns/1ps
interface nlc_if;
  logic       req_valid;
  logic       req_ready;
  logic       req_last;
  logic [7:0] req_data;
  logic       rsp_valid;
  logic       rsp_ready;
  logic       rsp_last;
  logic [7:0] rsp_data;

  modport host (
    output req_valid, req_last, req_data, rsp_ready,
    input  req_ready, rsp_valid, rsp_last, rsp_data
  );
  modport device (
    input  req_valid, req_last, req_data, rsp_ready,
    output req_ready, rsp_valid, rsp_last, rsp_data
  );
endinterface : nlc_if

// ### nlc_param_store.sv
// Permanent parameter memory, one nibble per node, untouched by reset
`timescale 1ns/1ps
module nlc_param_store
  import nlc_pkg::*;
(
  // Clock
  input  wire logic              i_ref_clk,
  input  wire logic              i_ce,
  // Write port
  input  wire logic              i_wr_en,
  input  wire logic [ADDR_W-1:0] i_wr_addr,
  input  wire logic [3:0]        i_wr_data,
  // Read port
  input  wire logic [ADDR_W-1:0] i_rd_addr,
  output logic      [3:0]        o_rd_data
);
  // Contents hold across reset, standing in for the non-volatile array;
  // a declaration value keeps the clocked process the only writer
  logic [3:0] mem [0:NODES-1] = '{default: PARAM_DEFAULT};

  always_ff @(posedge i_ref_clk) begin
    if (i_ce && i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data; // RL13
    end
  end

  assign o_rd_data = mem[i_rd_addr];
endmodule : nlc_param_store

// ### nlc_device.sv
// Device end: serves node list, ident write and permanent parameter commands
`timescale 1ns/1ps
module nlc_device
  import nlc_pkg::*;
(
  // Clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst,
  input  wire logic              i_ce,
  // Host side
  nlc_if.device                  bus,
  // Node state from the sensor bus master
  input  wire logic [NODES-1:0]  i_periph_fault,
  input  wire logic [NODES-1:0]  i_projected_node_list,
  input  wire logic [NODES-1:0]  i_enabled_node_list,
  input  wire logic [NODES-1:0]  i_detected_node_list,
  // Node write port to the sensor bus master
  output logic                   o_node_wr_valid,
  input  wire logic              i_node_wr_ready,
  output nlc_node_wr_type        o_node_wr_kind,
  output logic      [ADDR_W-1:0] o_node_wr_addr,
  output logic      [3:0]        o_node_wr_data,
  // Status
  output logic      [NODES-1:0]  o_peripheral_fault_list,
  output logic                   o_replay_busy
);
  typedef enum logic [2:0] {ST_REPLAY, ST_RECV, ST_EXEC, ST_NODE, ST_RESP} nlc_dev_state_type;

  localparam logic [10:0] REFRESH_LAST = 11'(REFRESH_CYCLES - 1);

  nlc_dev_state_type state;
  logic [7:0]        req_buf [0:3];
  logic [2:0]        req_cnt;
  logic [10:0]       refresh_cnt;
  logic [ADDR_W-1:0] replay_idx;
  logic [79:0]       rsp_shift;
  logic [3:0]        rsp_idx;
  logic [3:0]        rsp_len;
  logic [6:0]        next_err;
  logic [63:0]       next_list;
  logic              is_list_op;
  logic              store_wr;
  logic [3:0]        store_rd_data;
  logic              req_take;
  logic              rsp_take;

  // ****************************************
  // Handshakes
  // ****************************************
  assign bus.req_ready = (state == ST_RECV) && i_ce;
  assign bus.rsp_valid = (state == ST_RESP) && i_ce;
  assign bus.rsp_data  = rsp_shift[79:72];
  assign bus.rsp_last  = (rsp_idx == rsp_len - 4'h1);
  assign req_take      = bus.req_valid && bus.req_ready;
  assign rsp_take      = bus.rsp_valid && bus.rsp_ready;
  assign o_replay_busy = (state == ST_REPLAY);

  // ****************************************
  // Peripheral fault list refresh
  // ****************************************
  // Only enabled and detected nodes may show a fault; others read 0
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      refresh_cnt             <= 11'h000;
      o_peripheral_fault_list <= 64'h0000_0000_0000_0000;
    end else if (i_ce) begin
      if (refresh_cnt == REFRESH_LAST) begin
        refresh_cnt             <= 11'h000;
        o_peripheral_fault_list <= i_periph_fault & i_enabled_node_list
                                   & i_detected_node_list; // RL2 RL3 RL4
      end else begin
        refresh_cnt <= refresh_cnt + 11'h001; // RL2
      end
    end
  end

  // ****************************************
  // Request decode
  // ****************************************
  always_comb begin
    is_list_op = 1'b0;
    next_list  = 64'h0000_0000_0000_0000;
    case (req_buf[0])
      OP_FAULT_LIST: begin
        is_list_op = 1'b1;
        next_list  = o_peripheral_fault_list; // RL1
      end
      OP_PROJ_LIST: begin
        is_list_op = 1'b1;
        next_list  = i_projected_node_list; // RL16 RL17
      end
      OP_ENABLED_LIST: begin
        is_list_op = 1'b1;
        next_list  = i_enabled_node_list; // RL18 RL19
      end
      OP_DETECT_LIST: begin
        is_list_op = 1'b1;
        next_list  = i_detected_node_list; // RL20 RL21
      end
      default: begin
        is_list_op = 1'b0;
        next_list  = 64'h0000_0000_0000_0000;
      end
    endcase
  end

  // Overlong requests count past the buffer so they are refused, not truncated
  always_comb begin
    if (nlc_req_len(req_buf[0]) == 3'h0) begin
      next_err = ERR_OPCODE;
    end else if (req_cnt != nlc_req_len(req_buf[0])) begin
      next_err = ERR_LENGTH; // RL5
    end else if (req_buf[1][SEG_BIT]) begin
      next_err = ERR_SEGMENT;
    end else begin
      next_err = ERR_NONE;
    end
  end

  assign store_wr = (state == ST_EXEC) && (next_err == ERR_NONE)
                    && (req_buf[0] == OP_PERM_PARAM); // RL12

  nlc_param_store u_store (
    .i_ref_clk (i_ref_clk),
    .i_ce      (i_ce),
    .i_wr_en   (store_wr),
    .i_wr_addr (req_buf[2][AB_BIT:0]),
    .i_wr_data (req_buf[3][3:0]),
    .i_rd_addr (replay_idx),
    .o_rd_data (store_rd_data)
  );

  // ****************************************
  // Request capture
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      req_cnt <= 3'h0;
      for (int b = 0; b < 4; b++) begin
        req_buf[b] <= 8'h00;
      end
    end else if (i_ce) begin
      if (req_take) begin
        if (req_cnt < MAX_REQ_BYTES) begin
          req_buf[req_cnt[1:0]] <= bus.req_data; // RL23
        end
        if (req_cnt != 3'h7) begin
          req_cnt <= req_cnt + 3'h1;
        end
      end else if (state == ST_RESP) begin
        req_cnt <= 3'h0;
      end
    end
  end

  // ****************************************
  // Command sequencing and node writes
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state           <= ST_REPLAY;
      replay_idx      <= 6'h00;
      o_node_wr_valid <= 1'b0;
      o_node_wr_kind  <= NODE_WR_PARAM;
      o_node_wr_addr  <= 6'h00;
      o_node_wr_data  <= 4'h0;
    end else if (i_ce) begin
      case (state)
        ST_REPLAY: begin
          if (!o_node_wr_valid) begin
            if (replay_idx[4:0] != 5'h00) begin
              o_node_wr_valid <= 1'b1; // RL14
              o_node_wr_kind  <= NODE_WR_PARAM;
              o_node_wr_addr  <= replay_idx;
              o_node_wr_data  <= store_rd_data;
            end else begin
              replay_idx <= replay_idx + 6'h01;
            end
          end else if (i_node_wr_ready) begin
            o_node_wr_valid <= 1'b0;
            if (replay_idx == LAST_NODE) begin
              state <= ST_RECV;
            end else begin
              replay_idx <= replay_idx + 6'h01;
            end
          end
        end
        ST_RECV: begin
          if (req_take && bus.req_last) begin
            state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (next_err == ERR_NONE && req_buf[0] == OP_EXT_IDENT) begin
            o_node_wr_valid <= 1'b1; // RL7
            o_node_wr_kind  <= NODE_WR_IDENT;
            o_node_wr_addr  <= 6'h00;
            o_node_wr_data  <= req_buf[2][3:0]; // RL8
            state           <= ST_NODE;
          end else begin
            state <= ST_RESP;
          end
        end
        ST_NODE: begin
          if (i_node_wr_ready) begin
            o_node_wr_valid <= 1'b0;
            state           <= ST_RESP;
          end
        end
        ST_RESP: begin
          if (rsp_take && bus.rsp_last) begin
            state <= ST_RECV;
          end
        end
        default: begin
          state <= ST_RECV;
        end
      endcase
    end
  end

  // ****************************************
  // Response output
  // ****************************************
  // Header is loaded in the decode cycle, so a waiting node write cannot change it
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rsp_shift <= 80'h0000_0000_0000_0000_0000;
      rsp_idx   <= 4'h0;
      rsp_len   <= HDR_BYTES;
    end else if (i_ce) begin
      if (state == ST_EXEC) begin
        rsp_idx <= 4'h0;
        rsp_shift[79:64] <= {req_buf[0], req_buf[1][T_BIT], next_err}; // RL22
        if (is_list_op && next_err == ERR_NONE) begin
          rsp_shift[63:0] <= nlc_pack_list(next_list); // RL6
          rsp_len         <= RSP_LIST_LEN;
        end else begin
          rsp_shift[63:0] <= 64'h0000_0000_0000_0000;
          rsp_len         <= HDR_BYTES; // RL10 RL11
        end
      end else if (rsp_take) begin
        rsp_shift <= {rsp_shift[71:0], 8'h00};
        rsp_idx   <= rsp_idx + 4'h1;
      end
    end
  end
endmodule : nlc_device

// ### nlc_host.sv
// Host end: frames commands and collects responses of the node list handler
`timescale 1ns/1ps
module nlc_host
  import nlc_pkg::*;
(
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  // Command port
  input  wire logic        i_cmd_valid,
  output logic             o_cmd_ready,
  input  wire logic [7:0]  i_cmd_opcode,
  input  wire logic        i_cmd_segment,
  input  wire logic [7:0]  i_cmd_arg0,
  input  wire logic [7:0]  i_cmd_arg1,
  // Result port
  output logic             o_rsp_valid,
  output logic [7:0]       o_rsp_opcode,
  output logic [6:0]       o_rsp_error,
  output logic             o_rsp_t_ok,
  output logic [63:0]      o_rsp_list,
  // Device side
  nlc_if.host              bus
);
  typedef enum logic [1:0] {HS_IDLE, HS_SEND, HS_WAIT} nlc_host_state_type;

  nlc_host_state_type state;
  logic [31:0]        req_shift;
  logic [2:0]         req_len;
  logic [2:0]         req_idx;
  logic [3:0]         rsp_idx;
  logic               t_flag;
  logic [2:0]         next_len;

  assign next_len      = (nlc_req_len(i_cmd_opcode) == 3'h0) ? LEN_LIST_REQ
                         : nlc_req_len(i_cmd_opcode); // RL5 RL10 RL15
  assign o_cmd_ready   = (state == HS_IDLE) && i_ce;
  assign bus.req_valid = (state == HS_SEND) && i_ce;
  assign bus.req_data  = req_shift[31:24];
  assign bus.req_last  = (req_idx == req_len - 3'h1);
  assign bus.rsp_ready = (state == HS_WAIT) && i_ce;

  // ****************************************
  // Request framing and result capture
  // ****************************************
  // The handshake bit toggles per command so a stale response is recognised
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state        <= HS_IDLE;
      req_shift    <= 32'h0000_0000;
      req_len      <= LEN_LIST_REQ;
      req_idx      <= 3'h0;
      rsp_idx      <= 4'h0;
      t_flag       <= 1'b0;
      o_rsp_valid  <= 1'b0;
      o_rsp_opcode <= 8'h00;
      o_rsp_error  <= ERR_NONE;
      o_rsp_t_ok   <= 1'b0;
      o_rsp_list   <= 64'h0000_0000_0000_0000;
    end else if (i_ce) begin
      o_rsp_valid <= 1'b0;
      case (state)
        HS_IDLE: begin
          if (i_cmd_valid) begin
            req_shift <= {i_cmd_opcode, ~t_flag, 6'h00, i_cmd_segment,
                          i_cmd_arg0, i_cmd_arg1}; // RL23 RL9
            t_flag    <= ~t_flag;
            req_len   <= next_len;
            req_idx   <= 3'h0;
            state     <= HS_SEND;
          end
        end
        HS_SEND: begin
          if (bus.req_ready) begin
            req_shift <= {req_shift[23:0], 8'h00};
            req_idx   <= req_idx + 3'h1;
            if (bus.req_last) begin
              rsp_idx <= 4'h0;
              state   <= HS_WAIT;
            end
          end
        end
        HS_WAIT: begin
          if (bus.rsp_valid) begin
            rsp_idx <= rsp_idx + 4'h1;
            if (rsp_idx == 4'h0) begin
              o_rsp_opcode <= bus.rsp_data;
              o_rsp_list   <= 64'h0000_0000_0000_0000;
            end else if (rsp_idx == 4'h1) begin
              o_rsp_t_ok  <= (bus.rsp_data[T_BIT] == t_flag);
              o_rsp_error <= bus.rsp_data[6:0];
            end else if (rsp_idx < RSP_LIST_LEN) begin
              o_rsp_list <= {o_rsp_list[55:0], bus.rsp_data}; // RL6
            end
            if (bus.rsp_last) begin
              o_rsp_valid <= 1'b1;
              state       <= HS_IDLE;
            end
          end
        end
        default: begin
          state <= HS_IDLE;
        end
      endcase
    end
  end
endmodule : nlc_host

// ### nlc_assertions.sv
// Concurrent checks on the byte streams between the host and device ends
`timescale 1ns/1ps
module nlc_assertions
  import nlc_pkg::*;
(
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_ce,
  // Request stream
  input  wire logic       req_valid,
  input  wire logic       req_ready,
  input  wire logic       req_last,
  input  wire logic [7:0] req_data,
  // Response stream
  input  wire logic       rsp_valid,
  input  wire logic       rsp_ready,
  input  wire logic       rsp_last,
  input  wire logic [7:0] rsp_data
);
  logic [2:0] req_cnt;
  logic [3:0] rsp_cnt;
  logic [7:0] req_op;
  logic       req_t;
  logic       req_seg;
  logic       req_take;
  logic       rsp_take;
  logic       is_list;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst || !i_ce);

  assign req_take = req_valid && req_ready && i_ce;
  assign rsp_take = rsp_valid && rsp_ready && i_ce;
  assign is_list  = (req_op == OP_FAULT_LIST) || (req_op == OP_PROJ_LIST) ||
                    (req_op == OP_ENABLED_LIST) || (req_op == OP_DETECT_LIST);

  // ****************************************
  // Frame position trackers
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      req_cnt <= 3'h0;
    end else if (req_take) begin
      req_cnt <= req_last ? 3'h0 : req_cnt + 3'h1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rsp_cnt <= 4'h0;
    end else if (rsp_take) begin
      rsp_cnt <= rsp_last ? 4'h0 : rsp_cnt + 4'h1;
    end
  end

  // Header fields are kept so the answer can be held against its request
  always_ff @(posedge i_ref_clk) begin
    if (req_take && req_cnt == 3'h0) begin
      req_op <= req_data;
    end
    if (req_take && req_cnt == 3'h1) begin
      req_t   <= req_data[T_BIT];
      req_seg <= req_data[SEG_BIT];
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  a_req_hold_stable: assert property (req_valid && !req_ready |=>
    req_valid && $stable(req_data) && $stable(req_last))
    else $error("request byte changed before it was taken");
  a_list_answer_time: assert property (req_take && req_last && req_op != OP_EXT_IDENT
    |-> ##2 rsp_valid)
    else $error("response did not start two cycles after request end");
  a_ident_answer_time: assert property (req_take && req_last && req_op == OP_EXT_IDENT
    |-> ##[2:40] rsp_valid)
    else $error("ident response missing");
  a_opcode_echo: assert property (rsp_valid && rsp_cnt == 4'h0 |-> rsp_data == req_op)
    else $error("response byte 0 is not the request opcode");
  a_handshake_echo: assert property (rsp_valid && rsp_cnt == 4'h1 |-> rsp_data[7] == req_t)
    else $error("response handshake bit differs from request");
  a_segment_refused: assert property (rsp_valid && rsp_cnt == 4'h1 && req_seg && is_list
    |-> rsp_data[6:0] == ERR_SEGMENT)
    else $error("unserved segment not refused");
  a_header_end: assert property (rsp_valid && rsp_cnt == 4'h1
    |-> rsp_last == !(is_list && rsp_data[6:0] == ERR_NONE))
    else $error("header end marker wrong");
  a_list_length: assert property (rsp_valid && rsp_cnt >= 4'h2
    |-> rsp_last == (rsp_cnt == 4'h9))
    else $error("list payload not eight bytes");
  a_unused_bit: assert property (rsp_valid && (rsp_cnt == 4'h2 || rsp_cnt == 4'h6)
    |-> !rsp_data[0])
    else $error("unused address 0 bit set in list");
endmodule : nlc_assertions

// ### nlc_tb_top.sv
// Self-checking bench joining the host and device ends of the node list handler
`timescale 1ns/1ps
`define CHECK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
  $display("wrong value %s expected %h seen %h", nm, ex, got); err_count++; end end
module nlc_tb_top
  import nlc_pkg::*;
;
  logic i_ref_clk, i_rst, i_ce, cmd_valid, cmd_ready, cmd_seg, rsp_valid, rsp_t_ok;
  logic [7:0]  cmd_op, cmd_a0, cmd_a1, rsp_op;
  logic [6:0]  rsp_err;
  logic [63:0] rsp_list, fault, proj, en, det, flist;
  logic        wr_valid, wr_ready, replay_busy;
  nlc_node_wr_type wr_kind, last_kind;
  logic [5:0]  wr_addr, last_addr;
  logic [3:0]  wr_data, last_data;
  logic [3:0]  replay_val [64];
  logic [3:0]  exp_param [64];
  int          err_count, n_compared, n_wr, n_replay, base;

  nlc_if nlc_if_i ();
  nlc_device nlc_device_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(i_ce), .bus(nlc_if_i),
    .i_periph_fault(fault), .i_projected_node_list(proj), .i_enabled_node_list(en),
    .i_detected_node_list(det), .o_node_wr_valid(wr_valid), .i_node_wr_ready(wr_ready),
    .o_node_wr_kind(wr_kind), .o_node_wr_addr(wr_addr), .o_node_wr_data(wr_data),
    .o_peripheral_fault_list(flist), .o_replay_busy(replay_busy));
  nlc_host nlc_host_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready), .i_cmd_opcode(cmd_op),
    .i_cmd_segment(cmd_seg), .i_cmd_arg0(cmd_a0), .i_cmd_arg1(cmd_a1),
    .o_rsp_valid(rsp_valid), .o_rsp_opcode(rsp_op), .o_rsp_error(rsp_err),
    .o_rsp_t_ok(rsp_t_ok), .o_rsp_list(rsp_list), .bus(nlc_if_i));
  nlc_assertions nlc_assertions_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(i_ce),
    .req_valid(nlc_if_i.req_valid), .req_ready(nlc_if_i.req_ready),
    .req_last(nlc_if_i.req_last), .req_data(nlc_if_i.req_data),
    .rsp_valid(nlc_if_i.rsp_valid), .rsp_ready(nlc_if_i.rsp_ready),
    .rsp_last(nlc_if_i.rsp_last), .rsp_data(nlc_if_i.rsp_data));

  initial begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end

  // Node side stalls every other cycle so write handshakes are not trivial
  always @(posedge i_ref_clk) begin
    wr_ready <= ~wr_ready;
    if (!i_rst && wr_valid && wr_ready) begin
      n_wr++;
      last_kind = wr_kind;
      last_addr = wr_addr;
      last_data = wr_data;
      if (replay_busy) begin
        n_replay++;
        replay_val[wr_addr] = wr_data;
      end
    end
  end

  function automatic logic [63:0] pack_exp(input logic [63:0] l);
    logic [63:0] r;
    for (int k = 0; k < 8; k++) begin
      r[(7-k)*8 +: 8] = l[k*8 +: 8];
    end
    r[56] = 1'b0;
    r[24] = 1'b0;
    return r;
  endfunction : pack_exp

  task automatic stop_test;
    $display("compares %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic give_up(input string what);
    $display("wrong value %s expected %h seen %h", what, 1'b1, 1'b0);
    err_count++;
    stop_test();
  endtask : give_up

  // Reset, then check that every stored parameter except those of nodes 0 and 32 is replayed to its node
  task automatic do_reset;
    int k;
    i_rst <= 1'b1;
    repeat (5) @(posedge i_ref_clk);
    n_replay = 0;
    i_rst <= 1'b0;
    k = 0;
    do begin
      @(posedge i_ref_clk);
      k++;
    end while ((replay_busy !== 1'b0 || k < 2) && k < 1000);
    if (k >= 1000) give_up("replay end");
    `CHECK("replay count", 62, n_replay)
    for (int a = 1; a < 64; a++) begin
      if (a != 32) `CHECK("replayed param", exp_param[a], replay_val[a])
    end
    $display("test reset replay done");
  endtask : do_reset

  task automatic run_cmd(input logic [7:0] op, input logic seg, input logic [7:0] a0,
                         input logic [7:0] a1, input logic [6:0] ex_err);
    int k;
    cmd_op <= op;
    cmd_seg <= seg;
    cmd_a0 <= a0;
    cmd_a1 <= a1;
    cmd_valid <= 1'b1;
    k = 0;
    do begin
      @(posedge i_ref_clk);
      k++;
    end while (cmd_ready !== 1'b1 && k < 200);
    if (cmd_ready !== 1'b1) give_up("command");
    cmd_valid <= 1'b0;
    k = 0;
    do begin
      @(posedge i_ref_clk);
      k++;
    end while (rsp_valid !== 1'b1 && k < 200);
    if (rsp_valid !== 1'b1) give_up("response");
    `CHECK("opcode echo", op, rsp_op)
    `CHECK("handshake echo", 1'b1, rsp_t_ok)
    `CHECK("error code", ex_err, rsp_err)
  endtask : run_cmd

  initial begin
    i_rst = 1'b1;
    i_ce = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = 8'h00;
    cmd_seg = 1'b0;
    cmd_a0 = 8'h00;
    cmd_a1 = 8'h00;
    wr_ready = 1'b0;
    fault = 64'hFFFF_0000_FFFF_FFFF;
    proj = 64'hF0E1_D2C3_B4A5_9687;
    en = 64'h8001_7FFF_5A5A_C3C3;
    det = 64'hFFFF_FF0F_F0FF_FFFF;
    err_count = 0;
    n_compared = 0;
    n_wr = 0;
    for (int a = 0; a < 64; a++) exp_param[a] = 4'hF;
    do_reset();
    run_cmd(OP_PROJ_LIST, 1'b0, 8'h00, 8'h00, ERR_NONE);
    `CHECK("projected list", pack_exp(proj), rsp_list)
    run_cmd(OP_ENABLED_LIST, 1'b0, 8'h00, 8'h00, ERR_NONE);
    `CHECK("enabled list", pack_exp(en), rsp_list)
    run_cmd(OP_DETECT_LIST, 1'b0, 8'h00, 8'h00, ERR_NONE);
    `CHECK("detected list", pack_exp(det), rsp_list)
    $display("test list reads done");
    // Refresh period is fixed at 2000 cycles, so 2100 always spans one snapshot
    repeat (2) begin
      repeat (2100) @(posedge i_ref_clk);
      run_cmd(OP_FAULT_LIST, 1'b0, 8'h00, 8'h00, ERR_NONE);
      `CHECK("fault list", pack_exp(fault & en & det), rsp_list)
      `CHECK("fault snapshot", fault & en & det, flist)
      fault <= ~fault;
    end
    $display("test fault list done");
    base = n_wr;
    run_cmd(OP_EXT_IDENT, 1'b0, 8'hA6, 8'h00, ERR_NONE);
    `CHECK("ident writes", base + 1, n_wr)
    `CHECK("ident kind", NODE_WR_IDENT, last_kind)
    `CHECK("ident addr", 6'h00, last_addr)
    `CHECK("ident code", 4'h6, last_data)
    run_cmd(OP_EXT_IDENT, 1'b1, 8'h05, 8'h00, ERR_SEGMENT);
    `CHECK("refused writes", base + 1, n_wr)
    run_cmd(8'h47, 1'b0, 8'h00, 8'h00, ERR_OPCODE);
    run_cmd(OP_PROJ_LIST, 1'b1, 8'h00, 8'h00, ERR_SEGMENT);
    $display("test ident and errors done");
    run_cmd(OP_PERM_PARAM, 1'b0, 8'h25, 8'hFA, ERR_NONE);
    exp_param[6'h25] = 4'hA;
    run_cmd(OP_PERM_PARAM, 1'b0, 8'h03, 8'h07, ERR_NONE);
    exp_param[6'h03] = 4'h7;
    $display("test permanent params done");
    do_reset();
    stop_test();
  end
endmodule : nlc_tb_top
